// ==== pkg/ring_arb_pkg.sv ====
/*
 * Shared constants and carrier types for the ring token arbitration opcode block.
 * Assumes one reference clock at 100 MHz drives both the receiver and the sender.
 */
package ring_arb_pkg;

   // di-bit symbol codes
   localparam logic [1:0] SYM_SYNC = 2'h3;
   localparam logic [1:0] SYM_ZERO = 2'h0;
   localparam logic [1:0] SYM_ONE = 2'h1;
   localparam logic [1:0] SYM_BAD = 2'h2;

   // opcode lengths in bits
   localparam logic [4:0] LEN_IDLE = 5'h06;
   localparam logic [4:0] LEN_TOKEN = 5'h06;
   localparam logic [4:0] LEN_FLUSH = 5'h10;
   localparam logic [4:0] LEN_XOFF = 5'h0C;
   localparam logic [4:0] LEN_XON = 5'h12;

   // opcode patterns, left aligned in 18 bits, msb sent first
   localparam logic [17:0] PAT_IDLE = 18'h30000;
   localparam logic [17:0] PAT_TOKEN = 18'h34000;
   localparam logic [17:0] PAT_FLUSH = 18'h35000;
   localparam logic [17:0] PAT_XOFF = 18'h31000;
   localparam logic [17:0] PAT_XON = 18'h31400;
   localparam int MEMBER_SHIFT = 4;

   // timing limits
   localparam int CLK_PERIOD_NS = 10;
   localparam int DECODE_LATENCY_NS = 80;
   localparam int TOKEN_TO_DATA_NS = 320;
   localparam int DECODE_LATENCY_CYC = DECODE_LATENCY_NS / CLK_PERIOD_NS;
   localparam int TOKEN_TO_DATA_CYC = TOKEN_TO_DATA_NS / CLK_PERIOD_NS;

   localparam logic [15:0] PAUSE_OFF = 16'hFFFF;
   localparam logic [15:0] PAUSE_ON = 16'h0000;

   typedef enum logic [2:0] {
      TK_NONE,
      TK_PAUSE_PRE,
      TK_ITEM,
      TK_PAUSE_POST,
      TK_PASS
   } tok_state_t;

   typedef enum logic [2:0] {
      OP_NONE,
      OP_IDLE,
      OP_TOKEN,
      OP_FLUSH,
      OP_XOFF,
      OP_XON
   } opcode_t;

   typedef struct packed {
      opcode_t op;
      logic [2:0] member;
   } ring_op_t;

   // pause frame request towards the receive-line data path
   typedef struct packed {
      logic valid;
      logic is_pause;
      logic [15:0] pause_time;
   } send_req_t;

endpackage

// ==== sim/ring_peer.sv ====
/* Neighbour package on the ring: idle opcodes back to back, one given opcode on request.
   Assumes go_i and its pattern are held until taken_o is seen at a rising edge. */
`timescale 1ns/1ps
module ring_peer (
   input logic clk_i,
   input logic rst_b_i,
   input logic go_i,
   input logic [17:0] pat_i,
   input logic [4:0] len_i,
   output logic ring_o,
   output logic taken_o
);
   logic [17:0] sh_q;
   logic [4:0] cnt_q;
   assign ring_o = sh_q[17];
   assign taken_o = cnt_q <= 5'h01;
   always_ff @(posedge clk_i) begin
      // reset preloads idle so the first bit after release is a symbol's first half
      if (!rst_b_i) begin
         sh_q <= ring_arb_pkg::PAT_IDLE;
         cnt_q <= ring_arb_pkg::LEN_IDLE;
      end else if (taken_o) begin
         sh_q <= go_i ? pat_i : ring_arb_pkg::PAT_IDLE;
         cnt_q <= go_i ? len_i : ring_arb_pkg::LEN_IDLE;
      end else begin
         sh_q <= {sh_q[16:0], 1'h0};
         cnt_q <= cnt_q - 5'h01;
      end
   end
endmodule

// ==== sim/ring_token_arbiter_asserts.sv ====
/* Port assertions for the ring token arbiter.
   Assumes a bind onto ring_token_arbiter, one clock, synchronous low reset. */
`timescale 1ns/1ps
module ring_token_arbiter_asserts (
   input logic clk_i,
   input logic rst_b_i,
   input logic ring_symbol_input_i,
   input logic [2:0] ring_member_number_i,
   input logic ready_i,
   input logic token_timeout_i,
   input logic flow_ctrl_en_i,
   input logic congested_i,
   input logic reissue_pause_i,
   input logic item_pending_i,
   input logic item_done_i,
   input logic ring_symbol_output_o,
   input logic rx_drive_en_o,
   input logic item_go_o,
   input ring_arb_pkg::send_req_t pause_req_o,
   input logic has_token_o,
   input logic waiting_own_release_o,
   input logic timeout_clear_o
);
   localparam int TTD = ring_arb_pkg::TOKEN_TO_DATA_CYC;
   logic [7:0] obs_q;
   logic [3:0] zrun_q;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         obs_q <= 8'h00;
         zrun_q <= 4'h0;
      end else begin
         obs_q <= {obs_q[6:0], ring_symbol_output_o};
         zrun_q <= ring_symbol_output_o ? 4'h0 : zrun_q + 4'h1;
      end
   end
   sequence s_token_head;
      {obs_q[4:0], ring_symbol_output_o} == 6'h34;
   endsequence
   sequence s_flush_head;
      {obs_q[6:0], ring_symbol_output_o} == 8'hD4;
   endsequence
   // only a sync has two ones in a row, so a third one means a broken symbol
   AST_NO_TRIPLE_ONE: assert property (ring_symbol_output_o [*2] |=> !ring_symbol_output_o)
      else $error("three ones in a row on ring output");
   // longest legal zero run is ten, in a member field of zero
   AST_IDLE_FILL: assert property (zrun_q <= 4'hA)
      else $error("ring output silent too long");
   AST_TOKEN_TAIL_DRV: assert property ({obs_q[4:0], ring_symbol_output_o} == 6'h34
      |-> !rx_drive_en_o)
      else $error("drivers on at last token clock");
   AST_GRANT_TIME: assert property ($rose(timeout_clear_o) && item_pending_i && !congested_i
      |-> ##[1:TTD] rx_drive_en_o)
      else $error("drivers late after token");
   AST_ONE_ITEM: assert property (item_go_o |-> has_token_o ##1 !item_go_o)
      else $error("item start without token or repeated");
   AST_PAUSE_VAL: assert property (pause_req_o.valid |-> pause_req_o.is_pause && has_token_o
      && (pause_req_o.pause_time == 16'hFFFF || pause_req_o.pause_time == 16'h0000))
      else $error("bad pause request");
   AST_WAIT_ENTRY: assert property (flow_ctrl_en_i && $fell(congested_i)
      |-> ##[1:40] waiting_own_release_o)
      else $error("no waiting state after congestion");
   AST_FLUSH_START: assert property ($rose(ready_i) |-> ##[1:40] s_flush_head)
      else $error("no flush after ready");
   AST_PASS_LATENCY: assert property ($rose(timeout_clear_o) && !item_pending_i
      && !flow_ctrl_en_i |-> ##[1:20] s_token_head)
      else $error("token not passed on in time");
   AST_DRV_NEEDS_TOKEN: assert property (rx_drive_en_o |-> has_token_o)
      else $error("drivers on without token");
endmodule
bind ring_token_arbiter ring_token_arbiter_asserts i_ring_token_arbiter_asserts (.clk_i,
   .rst_b_i, .ring_symbol_input_i, .ring_member_number_i, .ready_i, .token_timeout_i,
   .flow_ctrl_en_i, .congested_i, .reissue_pause_i, .item_pending_i, .item_done_i,
   .ring_symbol_output_o, .rx_drive_en_o, .item_go_o, .pause_req_o, .has_token_o,
   .waiting_own_release_o, .timeout_clear_o);

// ==== sim/test_ring_token_arbiter.sv ====
/* Self-checking bench: neighbour model on the ring input, small data path responder.
   Assumes a 100 MHz clock and member number 3. */
`timescale 1ns/1ps
module test_ring_token_arbiter;
   logic clk_i = 1'h0;
   logic rst_b_i = 1'h0;
   logic [2:0] mem = 3'h3;
   logic ready = 1'h0, tmo = 1'h0, fc = 1'h0, cong = 1'h0, pend = 1'h0, done = 1'h0, rei = 1'h0;
   logic go = 1'h0;
   logic [17:0] pat = 18'h00000;
   logic [4:0] len = 5'h06;
   logic rin, rout, drv, igo, tok, wt, tclr, taken;
   ring_arb_pkg::send_req_t preq;
   logic [17:0] obs = 18'h00000;
   logic [15:0] ptime = 16'h0000;
   int fail_count = 0, checked = 0, ntc = 0, ngo = 0, ndrv = 0, dcnt = 0, cyc = 0;
   ring_peer i_ring_peer (.clk_i, .rst_b_i, .go_i(go), .pat_i(pat), .len_i(len),
      .ring_o(rin), .taken_o(taken));
   ring_token_arbiter i_ring_token_arbiter (.clk_i, .rst_b_i, .ring_symbol_input_i(rin),
      .ring_member_number_i(mem), .ready_i(ready), .token_timeout_i(tmo),
      .flow_ctrl_en_i(fc), .congested_i(cong), .reissue_pause_i(rei),
      .item_pending_i(pend), .item_done_i(done), .ring_symbol_output_o(rout),
      .rx_drive_en_o(drv), .item_go_o(igo), .pause_req_o(preq), .has_token_o(tok),
      .waiting_own_release_o(wt), .timeout_clear_o(tclr));
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   always @(posedge clk_i) begin
      obs <= {obs[16:0], rout};
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         wrap_up();
      end
   end
   // data path stand-in: every item or pause frame lasts ten cycles
   always @(negedge clk_i) begin
      if (tclr === 1'h1) ntc++;
      if (igo === 1'h1) ngo++;
      if (drv === 1'h1) ndrv++;
      if (preq.valid === 1'h1) ptime = preq.pause_time;
      if (igo === 1'h1 || preq.valid === 1'h1) dcnt = 10;
      else if (dcnt > 0) dcnt--;
      done = dcnt == 1;
   end
   task automatic check(input string what, input logic [17:0] got, input logic [17:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [17:0] xon(input logic [2:0] m);
      return {10'h314, 1'h0, m[2], 1'h0, m[1], 1'h0, m[0], 2'h0};
   endfunction
   function automatic logic [17:0] flush(input logic [2:0] m);
      return {8'hD4, 1'h0, m[2], 1'h0, m[1], 1'h0, m[0], 4'h0};
   endfunction
   task automatic send(input logic [17:0] p, input logic [4:0] n);
      @(negedge clk_i);
      go = 1'h1;
      pat = p;
      len = n;
      while (taken !== 1'h1) @(negedge clk_i);
      @(negedge clk_i);
      go = 1'h0;
   endtask
   // looks for a left aligned pattern among the newest ring output bits
   task automatic seek(input string what, input logic [17:0] p, input logic [4:0] n,
      input logic want);
      logic [17:0] m;
      logic hit;
      m = 18'h3FFFF >> (5'h12 - n);
      hit = 1'h0;
      for (int i = 0; i < 80 && !(hit && want); i++) begin
         @(negedge clk_i);
         if (((obs ^ (p >> (5'h12 - n))) & m) == 18'h00000) hit = 1'h1;
      end
      check(what, hit, want);
   endtask
   task automatic t_idle;
      check("drive after reset", drv, 1'h0);
      seek("idle pair", {12'hC30, 6'h00}, 5'h0C, 1'h1);
      $display("test idle done");
   endtask
   task automatic t_pass;
      int n;
      n = ntc;
      send(ring_arb_pkg::PAT_TOKEN, 5'h0A);
      seek("token passed", ring_arb_pkg::PAT_TOKEN, ring_arb_pkg::LEN_TOKEN, 1'h1);
      check("token taken", 18'(ntc - n), 18'h1);
      check("no drive", 18'(ndrv), 18'h0);
      $display("test pass done");
   endtask
   task automatic t_bad;
      int n;
      n = ntc;
      send(ring_arb_pkg::PAT_TOKEN, 5'h04);
      send(18'h38000, ring_arb_pkg::LEN_TOKEN);
      seek("token dropped", ring_arb_pkg::PAT_TOKEN, ring_arb_pkg::LEN_TOKEN, 1'h0);
      check("no grant", 18'(ntc - n), 18'h0);
      $display("test bad done");
   endtask
   task automatic t_data;
      int n;
      n = ngo;
      pend = 1'h1;
      send(ring_arb_pkg::PAT_TOKEN, ring_arb_pkg::LEN_TOKEN);
      seek("token after item", ring_arb_pkg::PAT_TOKEN, ring_arb_pkg::LEN_TOKEN, 1'h1);
      check("one item", 18'(ngo - n), 18'h1);
      check("drive used", 18'(ndrv > 0), 18'h1);
      check("drive off", drv, 1'h0);
      pend = 1'h0;
      $display("test data done");
   endtask
   task automatic t_fc;
      for (int f = 0; f < 2; f++) begin
         fc = f[0];
         send(ring_arb_pkg::PAT_XOFF, ring_arb_pkg::LEN_XOFF);
         seek("xoff on", ring_arb_pkg::PAT_XOFF, ring_arb_pkg::LEN_XOFF, 1'h1);
         send(xon(3'h5), ring_arb_pkg::LEN_XON);
         seek("xon on", xon(3'h5), ring_arb_pkg::LEN_XON, 1'h1);
      end
      $display("test flow forward done");
   endtask
   task automatic t_cong;
      cong = 1'h1;
      ptime = 16'h1234;
      seek("xoff sent", ring_arb_pkg::PAT_XOFF, ring_arb_pkg::LEN_XOFF, 1'h1);
      rei = 1'h1;
      @(negedge clk_i);
      rei = 1'h0;
      seek("xoff reissued", ring_arb_pkg::PAT_XOFF, ring_arb_pkg::LEN_XOFF, 1'h1);
      send(xon(3'h5), ring_arb_pkg::LEN_XON);
      seek("xon dropped", xon(3'h5), ring_arb_pkg::LEN_XON, 1'h0);
      send(ring_arb_pkg::PAT_TOKEN, ring_arb_pkg::LEN_TOKEN);
      seek("token after pause", ring_arb_pkg::PAT_TOKEN, ring_arb_pkg::LEN_TOKEN, 1'h1);
      check("xoff time", ptime, 16'hFFFF);
      $display("test congestion done");
   endtask
   task automatic t_clear;
      cong = 1'h0;
      ptime = 16'h1234;
      seek("own xon", xon(3'h3), ring_arb_pkg::LEN_XON, 1'h1);
      check("waiting", wt, 1'h1);
      send(xon(3'h3), ring_arb_pkg::LEN_XON);
      send(ring_arb_pkg::PAT_TOKEN, ring_arb_pkg::LEN_TOKEN);
      seek("token after resume", ring_arb_pkg::PAT_TOKEN, ring_arb_pkg::LEN_TOKEN, 1'h1);
      check("resume time", ptime, 16'h0000);
      check("equal leaves", wt, 1'h0);
      cong = 1'h1;
      seek("xoff again", ring_arb_pkg::PAT_XOFF, ring_arb_pkg::LEN_XOFF, 1'h1);
      cong = 1'h0;
      seek("own xon again", xon(3'h3), ring_arb_pkg::LEN_XON, 1'h1);
      send(xon(3'h6), ring_arb_pkg::LEN_XON);
      seek("higher replaced", xon(3'h6), ring_arb_pkg::LEN_XON, 1'h0);
      check("higher stays", wt, 1'h1);
      send(xon(3'h1), ring_arb_pkg::LEN_XON);
      seek("lower forwarded", xon(3'h1), ring_arb_pkg::LEN_XON, 1'h1);
      check("lower leaves", wt, 1'h0);
      $display("test clear done");
   endtask
   task automatic t_flush;
      ready = 1'h1;
      seek("flush on ready", flush(3'h3), ring_arb_pkg::LEN_FLUSH, 1'h1);
      ready = 1'h0;
      tmo = 1'h1;
      @(negedge clk_i);
      tmo = 1'h0;
      seek("flush on timeout", flush(3'h3), ring_arb_pkg::LEN_FLUSH, 1'h1);
      send(flush(3'h1), ring_arb_pkg::LEN_FLUSH);
      seek("flush forwarded", flush(3'h1), ring_arb_pkg::LEN_FLUSH, 1'h1);
      $display("test flush done");
   endtask
   initial begin
      repeat (8) @(negedge clk_i);
      rst_b_i = 1'h1;
      t_idle();
      t_pass();
      t_bad();
      t_data();
      t_fc();
      t_cong();
      t_clear();
      t_flush();
      wrap_up();
   end
endmodule

// ==== src/ring_op_decoder.sv ====
/*
 * Ring symbol receiver: assembles di-bit symbols into opcodes.
 * Assumes ring_symbol_input is synchronous to clk_i.
 */
`timescale 1ns/1ps
module ring_op_decoder (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ring_symbol_input_i,
   output ring_arb_pkg::ring_op_t op_o,
   output logic op_valid_o
);
   typedef struct packed {
      logic half;
      logic first;
      logic in_op;
      logic done;
      logic [4:0] nsym;
      logic [7:0] bits;
      ring_arb_pkg::ring_op_t op;
      logic valid;
   } dec_state_t;

   dec_state_t s_q, s_d;
   logic [1:0] sym;
   logic [8:0] nb;

   always_comb begin
      s_d = s_q;
      s_d.valid = 1'b0;
      sym = {s_q.first, ring_symbol_input_i};
      nb = {s_q.bits, 1'b0};
      s_d.half = ~s_q.half;
      if (!s_q.half) begin
         s_d.first = ring_symbol_input_i;
      end else if (sym == ring_arb_pkg::SYM_SYNC) begin
         // new sync ends any partial opcode; a short one is dropped silently
         s_d.in_op = 1'b1;
         s_d.done = 1'b0;
         s_d.nsym = 5'h00;
         s_d.bits = 8'h00;
      end else if (sym == ring_arb_pkg::SYM_BAD) begin
         s_d.in_op = 1'b0;
      end else if (s_q.in_op && !s_q.done) begin
         nb = {s_q.bits, sym[0]};
         s_d.bits = nb[7:0];
         s_d.nsym = s_q.nsym + 5'h01;
         // opcode complete: trailing bits are ignored until next sync
         if (s_q.nsym == 5'h01 && nb[1:0] == 2'b00) begin
            s_d.done = 1'b1;
            s_d.valid = 1'b1;
            s_d.op.op = ring_arb_pkg::OP_IDLE;
         end else if (s_q.nsym == 5'h01 && nb[1:0] == 2'b10) begin
            s_d.done = 1'b1;
            s_d.valid = 1'b1;
            s_d.op.op = ring_arb_pkg::OP_TOKEN;
         end else if (s_q.nsym == 5'h04 && nb[4:0] == 5'b01000) begin
            s_d.done = 1'b1;
            s_d.valid = 1'b1;
            s_d.op.op = ring_arb_pkg::OP_XOFF;
         end else if (s_q.nsym == 5'h06 && nb[6:4] == 3'b110 && nb[0] == 1'b0) begin
            s_d.done = 1'b1;
            s_d.valid = 1'b1;
            s_d.op.op = ring_arb_pkg::OP_FLUSH;
            s_d.op.member = nb[3:1];
         end else if (s_q.nsym == 5'h07 && nb[7:4] == 4'b0110 && nb[0] == 1'b0) begin
            s_d.done = 1'b1;
            s_d.valid = 1'b1;
            s_d.op.op = ring_arb_pkg::OP_XON;
            s_d.op.member = nb[3:1];
         end else if (s_q.nsym == 5'h07) begin
            s_d.in_op = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign op_o = s_q.op;
   assign op_valid_o = s_q.valid;
endmodule

// ==== src/ring_token_arbiter.sv ====
/*
 * Ring token arbiter: decodes ring opcodes, sends opcodes, gates receive-line drivers
 * and requests pause frames. Assumes the data path reports pending items and item end and
 * that the ring member number is stable once channel identifiers are assigned.
 */
// What this block does
// - symbols are di-bits: sync 11, zero 00, one 01, 10 illegal.
// - each ring output pulse lasts one reference clock, synchronous to it.
// - opcodes start with sync then ones and zeros; five opcodes exist.
// - idle is sync zero zero; token is sync one zero.
// - flush carries member number; congestion-on is sync zero one zero zero zero.
// - congestion-cleared is sync zero one one zero, member number, zero.
// - too few clocks between syncs marks an opcode truncated.
// - bits after a complete legal opcode are ignored until next sync.
// - truncated or illegal opcodes are discarded with no action.
// - reply opcode starts within decode latency limit, even mid-transmission; here it starts only once the opcode being sent ends.
// - token holder with data enables drivers within token-to-data limit.
// - drivers turn off before last clock of the outgoing token.
// - per token at most one item plus optionally one pause frame.
// - emit idle opcodes while driving the receive lines.
// - pass token on after transmission, or at once if idle.
// - emit idle opcodes back to back when nothing else pending.
// - send flush opcodes when ready or on token timeout.
// - flush during a packet waits until the packet ends.
// - without flow control forward congestion opcodes unchanged.
// - congested: congestion-on opcode without token, else one 0xFFFF pause frame.
// - still congested may reissue congestion-on or pause frame.
// - congestion-on received without token is forwarded.
// - token holder on congestion-on sends 0xFFFF pause, drops repeats meanwhile.
// - leaving congestion sends cleared opcode with own number, then waits.
// - congested member replaces received cleared opcode by idle.
// - neither congested nor waiting: forward congestion-cleared opcodes.
// - waiting: higher number substitute own, lower forward, equal resume.
`timescale 1ns/1ps
module ring_token_arbiter (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ring_symbol_input_i,
   input wire logic [2:0] ring_member_number_i,
   input wire logic ready_i,
   input wire logic token_timeout_i,
   input wire logic flow_ctrl_en_i,
   input wire logic congested_i,
   input wire logic reissue_pause_i,
   input wire logic item_pending_i,
   input wire logic item_done_i,
   output logic ring_symbol_output_o,
   output logic rx_drive_en_o,
   output logic item_go_o,
   output ring_arb_pkg::send_req_t pause_req_o,
   output logic has_token_o,
   output logic waiting_own_release_o,
   output logic timeout_clear_o
);
   typedef struct packed {
      ring_arb_pkg::tok_state_t tk;
      logic [17:0] shreg;
      logic [4:0] left;
      ring_arb_pkg::ring_op_t pend;
      logic pend_v;
      logic flush_wait;
      ring_arb_pkg::ring_op_t flush_op;
      logic cong_prev;
      logic paused;
      logic xoff_req;
      logic xon_req;
      logic waiting;
      logic out;
      logic drive;
      logic go;
      ring_arb_pkg::send_req_t pause;
      logic pause_busy;
      logic clr;
      logic ready_prev;
      logic tok;
   } arb_state_t;

   arb_state_t s_q, s_d;
   ring_arb_pkg::ring_op_t rx_op;
   logic rx_v;

   ring_op_decoder u_dec (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .ring_symbol_input_i(ring_symbol_input_i),
      .op_o(rx_op),
      .op_valid_o(rx_v)
   );

   function automatic logic [17:0] pattern(input ring_arb_pkg::ring_op_t o);
      logic [17:0] p;
      p = ring_arb_pkg::PAT_IDLE;
      case (o.op)
         ring_arb_pkg::OP_TOKEN: p = ring_arb_pkg::PAT_TOKEN;
         ring_arb_pkg::OP_FLUSH: p = ring_arb_pkg::PAT_FLUSH
            | ({15'h0000, o.member[2], 1'b0, o.member[1]} << 6)
            | ({17'h00000, o.member[0]} << 4);
         ring_arb_pkg::OP_XOFF: p = ring_arb_pkg::PAT_XOFF;
         ring_arb_pkg::OP_XON: p = ring_arb_pkg::PAT_XON
            | ({15'h0000, o.member[2], 1'b0, o.member[1]} << 4)
            | ({17'h00000, o.member[0]} << 2);
         default: p = ring_arb_pkg::PAT_IDLE;
      endcase
      return p;
   endfunction

   function automatic logic [4:0] oplen(input ring_arb_pkg::opcode_t o);
      logic [4:0] n;
      case (o)
         ring_arb_pkg::OP_FLUSH: n = ring_arb_pkg::LEN_FLUSH;
         ring_arb_pkg::OP_XOFF: n = ring_arb_pkg::LEN_XOFF;
         ring_arb_pkg::OP_XON: n = ring_arb_pkg::LEN_XON;
         default: n = ring_arb_pkg::LEN_IDLE;
      endcase
      return n;
   endfunction

   ring_arb_pkg::ring_op_t own_xon, own_flush, nxt;
   logic busy;

   always_comb begin
      s_d = s_q;
      s_d.go = 1'b0;
      s_d.clr = 1'b0;
      s_d.pause.valid = 1'b0;
      s_d.ready_prev = ready_i;
      s_d.cong_prev = congested_i;
      own_xon.op = ring_arb_pkg::OP_XON;
      own_xon.member = ring_member_number_i;
      own_flush.op = ring_arb_pkg::OP_FLUSH;
      own_flush.member = ring_member_number_i;
      nxt.op = ring_arb_pkg::OP_IDLE;
      nxt.member = 3'h0;
      busy = s_q.tk != ring_arb_pkg::TK_NONE;

      // local congestion and flush request events
      if (congested_i && !s_q.cong_prev) begin
         s_d.paused = 1'b0;
         s_d.waiting = 1'b0;
         s_d.xon_req = 1'b0;
         s_d.xoff_req = 1'b1;
      end else if (congested_i && reissue_pause_i) begin
         s_d.paused = 1'b0;
         s_d.xoff_req = 1'b1;
      end
      if (!congested_i && s_q.cong_prev) begin
         s_d.pend = own_xon;
         s_d.pend_v = 1'b1;
         s_d.waiting = 1'b1;
      end
      if (ready_i && !s_q.ready_prev || token_timeout_i) begin
         s_d.flush_op = own_flush;
         s_d.flush_wait = 1'b1;
      end

      // received opcode handling
      if (rx_v) begin
         case (rx_op.op)
            ring_arb_pkg::OP_TOKEN: begin
               if (!busy) begin
                  s_d.clr = 1'b1;
                  s_d.tk = ring_arb_pkg::TK_PAUSE_PRE;
               end
            end
            ring_arb_pkg::OP_FLUSH: begin
               // acted on only once no packet is on the receive lines
               s_d.flush_op = rx_op.member < ring_member_number_i ? rx_op : own_flush;
               s_d.flush_wait = 1'b1;
            end
            ring_arb_pkg::OP_XOFF: begin
               if (!flow_ctrl_en_i || !busy) begin
                  s_d.pend = rx_op;
                  s_d.pend_v = 1'b1;
               end else if (!s_q.pause_busy && s_q.tk != ring_arb_pkg::TK_ITEM) begin
                  s_d.paused = 1'b0;
                  s_d.xoff_req = 1'b1;
               end
            end
            ring_arb_pkg::OP_XON: begin
               if (!flow_ctrl_en_i) begin
                  s_d.pend = rx_op;
                  s_d.pend_v = 1'b1;
               end else if (congested_i) begin
                  s_d.pend.op = ring_arb_pkg::OP_IDLE;
                  s_d.pend_v = 1'b1;
               end else if (!s_q.waiting) begin
                  s_d.pend = rx_op;
                  s_d.pend_v = 1'b1;
               end else if (rx_op.member > ring_member_number_i) begin
                  s_d.pend = own_xon;
                  s_d.pend_v = 1'b1;
               end else if (rx_op.member < ring_member_number_i) begin
                  s_d.pend = rx_op;
                  s_d.pend_v = 1'b1;
                  s_d.waiting = 1'b0;
               end else begin
                  s_d.xon_req = 1'b1;
                  s_d.waiting = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end

      // token holding sequence: optional pause, at most one item, optional pause, pass
      case (s_q.tk)
         ring_arb_pkg::TK_NONE: begin
         end
         ring_arb_pkg::TK_PAUSE_PRE: begin
            // a congestion already announced by opcode still gets its frame here
            if ((s_q.xoff_req || congested_i) && !s_q.paused && !s_q.pause_busy) begin
               s_d.pause.valid = 1'b1;
               s_d.pause.is_pause = 1'b1;
               s_d.pause.pause_time = ring_arb_pkg::PAUSE_OFF;
               s_d.paused = 1'b1;
               s_d.xoff_req = 1'b0;
               s_d.pause_busy = 1'b1;
               s_d.drive = 1'b1;
            end else if (s_q.pause_busy) begin
               s_d.pause_busy = !item_done_i;
            end else if (item_pending_i) begin
               s_d.go = 1'b1;
               s_d.drive = 1'b1;
               s_d.tk = ring_arb_pkg::TK_ITEM;
            end else begin
               s_d.tk = ring_arb_pkg::TK_PAUSE_POST;
            end
         end
         ring_arb_pkg::TK_ITEM: begin
            if (item_done_i) begin
               s_d.tk = ring_arb_pkg::TK_PAUSE_POST;
            end
         end
         ring_arb_pkg::TK_PAUSE_POST: begin
            if (s_q.xon_req && !s_q.pause_busy) begin
               s_d.pause.valid = 1'b1;
               s_d.pause.is_pause = 1'b1;
               s_d.pause.pause_time = ring_arb_pkg::PAUSE_ON;
               s_d.xon_req = 1'b0;
               s_d.pause_busy = 1'b1;
               s_d.drive = 1'b1;
            end else if (s_q.pause_busy) begin
               s_d.pause_busy = !item_done_i;
            end else begin
               s_d.tk = ring_arb_pkg::TK_PASS;
            end
         end
         ring_arb_pkg::TK_PASS: begin
         end
         default: s_d.tk = ring_arb_pkg::TK_NONE;
      endcase
      if (s_q.tk == ring_arb_pkg::TK_PAUSE_POST || s_q.tk == ring_arb_pkg::TK_PASS) begin
         s_d.drive = s_q.pause_busy && !item_done_i;
      end

      // ring output serialiser, one bit per clock
      s_d.out = s_q.shreg[17];
      s_d.shreg = {s_q.shreg[16:0], 1'b0};
      s_d.left = s_q.left - 5'h01;
      if (s_q.left <= 5'h01) begin
         // priority: token pass, then flush, then pending opcode, then congestion-on, else idle
         if (s_q.tk == ring_arb_pkg::TK_PASS) begin
            nxt.op = ring_arb_pkg::OP_TOKEN;
            s_d.tk = ring_arb_pkg::TK_NONE;
            s_d.drive = 1'b0;
         end else if (s_q.flush_wait && s_q.tk != ring_arb_pkg::TK_ITEM && !s_q.pause_busy) begin
            nxt = s_q.flush_op;
            // a new request landing in this cycle survives the load only if its flush_op differs
            s_d.flush_wait = s_d.flush_wait && s_d.flush_op != s_q.flush_op;
         end else if (s_q.pend_v && s_q.tk == ring_arb_pkg::TK_NONE) begin
            nxt = s_q.pend;
            s_d.pend_v = s_d.pend_v && s_d.pend != s_q.pend;
         end else if (s_q.xoff_req && s_q.tk == ring_arb_pkg::TK_NONE && flow_ctrl_en_i) begin
            nxt.op = ring_arb_pkg::OP_XOFF;
            s_d.xoff_req = 1'b0;
         end else begin
            nxt.op = ring_arb_pkg::OP_IDLE;
         end
         s_d.shreg = pattern(nxt);
         s_d.left = oplen(nxt.op);
      end
      s_d.tok = s_d.tk != ring_arb_pkg::TK_NONE;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign ring_symbol_output_o = s_q.out;
   assign rx_drive_en_o = s_q.drive;
   assign item_go_o = s_q.go;
   assign pause_req_o = s_q.pause;
   assign has_token_o = s_q.tok;
   assign waiting_own_release_o = s_q.waiting;
   assign timeout_clear_o = s_q.clr;
endmodule
